// File: hw/lpw_pkg.sv
// package: modes, states, widths and timing constants of the low-power sequencer
package lpw_pkg;
	localparam int          LPW_N_WAKE      = 16;
	localparam int          LPW_N_FAST      = 19;
	localparam int          LPW_DB_W        = 8;
	localparam logic [7:0]  LPW_DB_RST      = 8'h03;
	localparam int          LPW_CLK_MHZ     = 100;
	localparam int          LPW_REG_UP_US   = 400;
	localparam int          LPW_REG_UP_CYC  = LPW_REG_UP_US * LPW_CLK_MHZ;
	localparam int          LPW_RC_UP_CYC   = 4;
	localparam int          LPW_CNT_W       = 16;
	// register offsets of the software port (word index)
	localparam logic [3:0]  LPW_A_CTRL      = 4'h0;
	localparam logic [3:0]  LPW_A_WEN       = 4'h1;
	localparam logic [3:0]  LPW_A_FEN       = 4'h2;
	localparam logic [3:0]  LPW_A_SRCEN     = 4'h3;
	localparam logic [3:0]  LPW_A_DEB       = 4'h4;
	localparam logic [3:0]  LPW_A_STAT      = 4'h5;
	localparam logic [3:0]  LPW_A_CAUSE     = 4'h6;
	// source enable bits
	localparam int          LPW_S_FORCE_WAKE_PIN      = 0;
	localparam int          LPW_S_SM        = 1;
	localparam int          LPW_S_RTC       = 2;
	localparam int          LPW_S_RTT       = 3;
	localparam int          LPW_S_USB       = 4;
	typedef enum logic [2:0] {
		LPW_ST_ACTIVE  = 3'b000,
		LPW_ST_SLEEP   = 3'b001,
		LPW_ST_WAIT    = 3'b010,
		LPW_ST_BACKUP  = 3'b011,
		LPW_ST_REGUP   = 3'b100,
		LPW_ST_RCUP    = 3'b101
	} lpw_state_t;
endpackage

// File: hw/lpw_if.sv
// interface: core-side sleep request and status between the core end and the sequencer
`timescale 1ns/1ps
interface lpw_if;
	logic wait_for_event_instr;
	logic wait_for_interrupt_instr;
	logic deep_sleep_request;
	logic irq;
	logic core_clk_en;
	logic core_rst;
	logic awake;
	modport dev  (input wait_for_event_instr, input wait_for_interrupt_instr, input deep_sleep_request, input irq,
		output core_clk_en, output core_rst, output awake);
	modport core (output wait_for_event_instr, output wait_for_interrupt_instr, output deep_sleep_request, output irq,
		input core_clk_en, input core_rst, input awake);
endinterface

// File: hw/lpw_core_end.sv
// core end: issues sleep instructions from a software command port
`timescale 1ns/1ps
module lpw_core_end
	import lpw_pkg::*;
(
	input  wire logic  i_ref_clk,
	input  wire logic  i_rst,
	input  wire logic  i_go,
	input  wire logic  i_use_wfi,
	input  wire logic  i_deep,
	input  wire logic  i_irq,
	output logic       o_busy,
	lpw_if.core        lnk
);
	logic wfe_q, wfi_q, deep_q, irq_q, busy_q, awake_q;
	// --------------------------------
	// instruction issue
	// --------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			wfe_q  <= 1'b0;
			wfi_q  <= 1'b0;
			deep_q <= 1'b0;
			busy_q <= 1'b0;
			awake_q <= 1'b1;
		end else begin
			wfe_q <= i_go && !busy_q && !i_use_wfi;
			wfi_q <= i_go && !busy_q && i_use_wfi && !i_deep;
			awake_q <= lnk.awake;
			if (i_go && !busy_q) begin
				deep_q <= i_deep;
				// refused combination issues nothing, so nothing to wait for
				busy_q <= !(i_use_wfi && i_deep);
			end else if (lnk.awake && !awake_q) begin
				// only the clock's return ends the request, not the idle cycles before the stop
				busy_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			irq_q <= 1'b0;
		else
			irq_q <= i_irq;
	end
	assign lnk.wait_for_event_instr                = wfe_q;
	assign lnk.wait_for_interrupt_instr                = wfi_q;
	assign lnk.deep_sleep_request = deep_q;
	assign lnk.irq                = irq_q;
	assign o_busy                 = busy_q;
endmodule // lpw_core_end

// File: hw/lpw_seq.sv
// sequencer: low-power mode entry, wake-up sources and supply power-up sequence
//
// Function
// - backup keeps always-on domain, regulator off
// - wait-for-event with deep sleep enters backup
// - enabled wake events leave backup mode
// - backup wake resets core; pins held, pull-ups
// - wake restores core supply with no software
// - regulator control low backup, high otherwise
// - wait stops core, peripheral, memory clocks
// - event instruction, select one, enters wait
// - software selects RC clock before wait
// - software polls RC flag before wait
// - fast start-up events wake from wait
// - sleep stops only the core clock
// - select zero without deep sleep enters sleep
// - interrupt sleep ends on interrupt only
// - low enabled fast input starts wait wake
// - fast start-up request is combinational
// - request restarts RC, switches clock, core on
// - wake-up always runs from fast RC
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module lpw_seq
	import lpw_pkg::*;
#(
	parameter int REG_UP_CYC = LPW_REG_UP_CYC
) (
	input  wire logic                     i_ref_clk,
	input  wire logic                     i_rst,
	input  wire logic                     i_slck_tick,
	input  wire logic                     i_force_wake_pin_n,
	input  wire logic [LPW_N_WAKE-1:0]    i_wake_inputs,
	input  wire logic [LPW_N_FAST-1:0]    i_fast_inputs_n,
	input  wire logic                     i_sm_alarm,
	input  wire logic                     i_rtc_alarm,
	input  wire logic                     i_rtt_alarm,
	input  wire logic                     i_usb_wake,
	input  wire logic [3:0]               i_addr,
	input  wire logic [31:0]              i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic [31:0]                   o_rdata,
	output logic                          o_regulator_shutdown_ctrl,
	output logic                          o_core_pwr_en,
	output logic                          o_periph_clk_en,
	output logic                          o_mem_clk_en,
	output logic                          o_pio_hold,
	output logic                          o_pio_pullup_in,
	output logic                          o_fast_rc_en,
	output logic                          o_mck_on_rc,
	output logic                          o_fast_startup_req,
	lpw_if.dev                            lnk
);
	lpw_state_t st_q;
	logic                   lps_q, rc_sel_q, rc_flag_q;
	logic [LPW_N_WAKE-1:0]  wen_q, wprev_q, wpend_q;
	logic [LPW_N_FAST-1:0]  fen_q;
	logic [4:0]             srcen_q;
	logic [LPW_DB_W-1:0]    deb_q;
	logic [LPW_DB_W-1:0]    dcnt_q [LPW_N_WAKE+1];
	logic [LPW_N_WAKE:0]    dok;
	logic [LPW_CNT_W-1:0]   cnt_q;
	logic [7:0]             cause_q;
	logic [31:0]            rdata_q;
	logic                   rst_core_q, ckon_q, pclk_q, reg_q, pwr_q, hold_q, pull_q;
	logic                   rc_q, onrc_q, fsr_q, wfi_mode_q;
	logic                   bk_wake, wt_wake, sl_wake, fast_any;
	// --------------------------------
	// fast start-up, no clock in the path
	// --------------------------------
	assign fast_any = |(~i_fast_inputs_n & fen_q);
	// --------------------------------
	// debouncers, one per pin
	// --------------------------------
	genvar g;
	generate
		for (g = 0; g <= LPW_N_WAKE; g++) begin : g_deb
			logic act;
			if (g == LPW_N_WAKE) begin : g_fw
				assign act = !i_force_wake_pin_n && srcen_q[LPW_S_FORCE_WAKE_PIN];
			end else begin : g_wk
				assign act = wen_q[g] && (i_wake_inputs[g] != wprev_q[g]);
			end
			always_ff @(posedge i_ref_clk) begin
				if (i_rst || !act || st_q != LPW_ST_BACKUP)
					dcnt_q[g] <= '0;
				else if (i_slck_tick && dcnt_q[g] != deb_q)
					dcnt_q[g] <= dcnt_q[g] + 1'b1;
			end
			assign dok[g] = act && (dcnt_q[g] == deb_q);
		end
	endgenerate
	assign bk_wake = (|dok) || (i_sm_alarm && srcen_q[LPW_S_SM])
		|| (i_rtc_alarm && srcen_q[LPW_S_RTC]) || (i_rtt_alarm && srcen_q[LPW_S_RTT]);
	assign wt_wake = fast_any || (i_rtc_alarm && srcen_q[LPW_S_RTC])
		|| (i_rtt_alarm && srcen_q[LPW_S_RTT]) || (i_usb_wake && srcen_q[LPW_S_USB]);
	assign sl_wake = lnk.irq || (!wfi_mode_q && wt_wake);
	// --------------------------------
	// mode sequencer
	// --------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			st_q       <= LPW_ST_ACTIVE;
			cnt_q      <= '0;
			wfi_mode_q <= 1'b0;
			wprev_q    <= '0;
		end else begin
			case (st_q)
				LPW_ST_ACTIVE: begin
					wprev_q <= i_wake_inputs;
					wfi_mode_q <= lnk.wait_for_interrupt_instr;
					if (lnk.wait_for_event_instr && lnk.deep_sleep_request)
						st_q <= LPW_ST_BACKUP;
					else if (lnk.wait_for_event_instr && lps_q)
						st_q <= LPW_ST_WAIT;
					else if (lnk.wait_for_event_instr || lnk.wait_for_interrupt_instr)
						st_q <= LPW_ST_SLEEP;
				end
				LPW_ST_SLEEP:  if (sl_wake) st_q <= LPW_ST_RCUP;
				LPW_ST_WAIT:   if (wt_wake) st_q <= LPW_ST_RCUP;
				LPW_ST_BACKUP: begin
					cnt_q <= '0;
					if (bk_wake) st_q <= LPW_ST_REGUP;
				end
				LPW_ST_REGUP: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q >= LPW_CNT_W'(REG_UP_CYC - 1)) begin
						cnt_q <= '0;
						st_q  <= LPW_ST_RCUP;
					end
				end
				LPW_ST_RCUP: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q >= LPW_CNT_W'(LPW_RC_UP_CYC - 1)) begin
						cnt_q <= '0;
						st_q  <= LPW_ST_ACTIVE;
					end
				end
				default: st_q <= LPW_ST_ACTIVE;
			endcase
		end
	end
	// --------------------------------
	// supply, clock and pin controls
	// --------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			reg_q <= 1'b1; pwr_q <= 1'b1; ckon_q <= 1'b1; pclk_q <= 1'b1;
			rst_core_q <= 1'b0; hold_q <= 1'b0; pull_q <= 1'b0;
			rc_q <= 1'b1; onrc_q <= 1'b1; fsr_q <= 1'b0;
		end else begin
			reg_q  <= (st_q != LPW_ST_BACKUP);
			pwr_q  <= (st_q != LPW_ST_BACKUP);
			ckon_q <= (st_q == LPW_ST_ACTIVE);
			pclk_q <= (st_q == LPW_ST_ACTIVE) || (st_q == LPW_ST_SLEEP);
			hold_q <= (st_q == LPW_ST_BACKUP);
			if (st_q == LPW_ST_REGUP) begin
				rst_core_q <= 1'b1;
				pull_q     <= 1'b1;
			end else if (st_q == LPW_ST_ACTIVE) begin
				rst_core_q <= 1'b0;
			end
			if (st_q == LPW_ST_ACTIVE && lnk.wait_for_event_instr) pull_q <= 1'b0;
			fsr_q <= (st_q == LPW_ST_WAIT) && fast_any;
			if (st_q == LPW_ST_RCUP) begin
				rc_q   <= 1'b1;
				onrc_q <= 1'b1;
			end else if (st_q == LPW_ST_ACTIVE) begin
				rc_q   <= rc_flag_q;
				onrc_q <= rc_sel_q;
			end
		end
	end
	// --------------------------------
	// software register port
	// --------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			lps_q <= 1'b0; rc_sel_q <= 1'b1; rc_flag_q <= 1'b1;
			wen_q <= '0; fen_q <= '0; srcen_q <= '0; deb_q <= LPW_DB_RST;
		end else if (st_q == LPW_ST_RCUP) begin
			// wake restarted the rc; keep it selected once active again
			// no software write can land here: the core is still stopped
			rc_sel_q  <= 1'b1;
			rc_flag_q <= 1'b1;
		end else if (i_wr) begin
			case (i_addr)
				LPW_A_CTRL: begin
					lps_q     <= i_wdata[0];
					rc_sel_q  <= i_wdata[1];
					rc_flag_q <= i_wdata[2];
				end
				LPW_A_WEN:   wen_q   <= i_wdata[LPW_N_WAKE-1:0];
				LPW_A_FEN:   fen_q   <= i_wdata[LPW_N_FAST-1:0];
				LPW_A_SRCEN: srcen_q <= i_wdata[4:0];
				LPW_A_DEB:   deb_q   <= i_wdata[LPW_DB_W-1:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			cause_q <= '0;
		else if (st_q == LPW_ST_BACKUP && bk_wake)
			cause_q <= {3'b000, |dok[LPW_N_WAKE-1:0], dok[LPW_N_WAKE], i_sm_alarm,
				i_rtc_alarm, i_rtt_alarm};
		else if (i_rd && i_addr == LPW_A_CAUSE)
			cause_q <= '0;
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			rdata_q <= '0;
		else if (i_rd) begin
			case (i_addr)
				LPW_A_CTRL:  rdata_q <= {29'h0, rc_q, onrc_q, lps_q};
				LPW_A_WEN:   rdata_q <= {16'h0, wen_q};
				LPW_A_FEN:   rdata_q <= {13'h0, fen_q};
				LPW_A_SRCEN: rdata_q <= {27'h0, srcen_q};
				LPW_A_DEB:   rdata_q <= {24'h0, deb_q};
				LPW_A_STAT:  rdata_q <= {29'h0, st_q};
				LPW_A_CAUSE: rdata_q <= {24'h0, cause_q};
				default:     rdata_q <= '0;
			endcase
		end else
			rdata_q <= '0;
	end
	assign o_rdata                   = rdata_q;
	assign o_regulator_shutdown_ctrl = reg_q;
	assign o_core_pwr_en             = pwr_q;
	assign o_periph_clk_en           = pclk_q;
	assign o_mem_clk_en              = pclk_q;
	assign o_pio_hold                = hold_q;
	assign o_pio_pullup_in           = pull_q;
	assign o_fast_rc_en              = rc_q;
	assign o_mck_on_rc               = onrc_q;
	// async request straight to the clock manager; registered copy holds it one cycle after wait is left
	assign o_fast_startup_req        = fast_any && (st_q == LPW_ST_WAIT || fsr_q);
	assign lnk.core_clk_en           = ckon_q;
	assign lnk.core_rst              = rst_core_q;
	assign lnk.awake                 = ckon_q;
endmodule // lpw_seq

// File: tb/lpw_props.sv
// checker: link-level properties between core end and sequencer
`timescale 1ns/1ps
module lpw_props
	import lpw_pkg::*;
#(
	parameter int REG_UP_CYC = LPW_REG_UP_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_wfe,
	input wire logic i_wfi,
	input wire logic i_deep_sleep_request,
	input wire logic i_irq,
	input wire logic i_core_clk_en,
	input wire logic i_core_rst,
	input wire logic i_awake
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	localparam int BK_MAX = REG_UP_CYC + 8;
	localparam int BK_MIN = REG_UP_CYC + LPW_RC_UP_CYC;
	logic        bk_q;
	logic        wi_q;
	logic        seen_q;
	logic [15:0] low_q;
	logic [15:0] rcnt_q;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// flags drop on the edge that sees the clock return, so assertions still see them
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || $rose(i_core_clk_en)) bk_q <= 1'b0;
		else if (i_wfe && i_deep_sleep_request) bk_q <= 1'b1;
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || $rose(i_core_clk_en)) wi_q <= 1'b0;
		else if (i_wfi) wi_q <= 1'b1;
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || $rose(i_core_clk_en)) seen_q <= 1'b0;
		else if (wi_q && i_irq) seen_q <= 1'b1;
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || i_core_clk_en) low_q <= 16'h0000;
		else low_q <= low_q + 16'h0001;
	end
	// core reset length counted: full supply ramp is far beyond a delay range
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || !i_core_rst) rcnt_q <= 16'h0000;
		else rcnt_q <= rcnt_q + 16'h0001;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_awake; $fell(i_awake) |-> $past(i_wfe, 2) || $past(i_wfi, 2); endproperty
	property p_stop; (i_wfe || i_wfi) && i_core_clk_en |-> ##2 !i_core_clk_en; endproperty
	property p_bk_entry;
		i_wfe && i_deep_sleep_request |-> ##2 (!i_core_clk_en)[*4];
	endproperty
	property p_wfi_deep; !(i_wfi && i_deep_sleep_request); endproperty
	property p_rst_off; i_core_rst |-> !i_core_clk_en; endproperty
	property p_rst_src; $rose(i_core_rst) |-> bk_q; endproperty
	property p_bk_done; i_core_rst |-> rcnt_q < BK_MAX; endproperty
	property p_bk_len; $rose(i_core_clk_en) && bk_q |-> low_q >= BK_MIN; endproperty
	property p_wfi_irq; $rose(i_core_clk_en) && wi_q |-> seen_q; endproperty
	a_awake: assert property (p_awake) else $error("clock stopped without instruction");
	a_stop: assert property (p_stop) else $error("core clock kept running");
	a_bk_entry: assert property (p_bk_entry) else $error("backup entry failed");
	a_wfi_deep: assert property (p_wfi_deep) else $error("wfi with deep sleep");
	a_rst_off: assert property (p_rst_off) else $error("clock on in reset");
	a_rst_src: assert property (p_rst_src) else $error("reset outside backup");
	a_bk_done: assert property (p_bk_done) else $error("backup wake too slow");
	a_bk_len: assert property (p_bk_len) else $error("backup wake too fast");
	a_wfi_irq: assert property (p_wfi_irq) else $error("wfi sleep ended w/o irq");
	c_bk: cover property ($rose(i_core_clk_en) && bk_q);
	c_wfi: cover property ($rose(i_core_clk_en) && wi_q);
	c_wait: cover property (i_wfe && !i_deep_sleep_request);
endmodule // lpw_props

// File: tb/tb_low_power_mode_wakeup_ctrl.sv
// testbench: sequencer and core end joined on the link
`timescale 1ns/1ps
module tb_low_power_mode_wakeup_ctrl import lpw_pkg::*;;
	localparam int RUP = 8;
	logic        clk = 1'b0, rst = 1'b1, tick = 1'b0, fw_n = 1'b1;
	logic        sm = 1'b0, rtc = 1'b0, real_time_timer = 1'b0, usb = 1'b0;
	logic        we = 1'b0, re = 1'b0, go = 1'b0, use_wfi = 1'b0, deep = 1'b0, irq = 1'b0;
	logic [15:0] wk = 16'h0000;
	logic [18:0] fst_n = 19'h7FFFF;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic        reg_on, pwr, pclk, mclk, hold, pull, rc_en, mck_rc, fsr, busy;
	int          n_fail = 0, n_tests = 0, n;
	always #5 clk = ~clk;
	always @(posedge clk) tick <= ~tick;
	lpw_if lpw_if_inst ();
	lpw_seq #(.REG_UP_CYC(RUP)) lpw_seq_inst (.i_ref_clk(clk), .i_rst(rst),
		.i_slck_tick(tick), .i_force_wake_pin_n(fw_n), .i_wake_inputs(wk),
		.i_fast_inputs_n(fst_n), .i_sm_alarm(sm), .i_rtc_alarm(rtc), .i_rtt_alarm(real_time_timer),
		.i_usb_wake(usb), .i_addr(addr), .i_wdata(wdat), .i_wr(we), .i_rd(re),
		.o_rdata(rdat), .o_regulator_shutdown_ctrl(reg_on), .o_core_pwr_en(pwr),
		.o_periph_clk_en(pclk), .o_mem_clk_en(mclk), .o_pio_hold(hold),
		.o_pio_pullup_in(pull), .o_fast_rc_en(rc_en), .o_mck_on_rc(mck_rc),
		.o_fast_startup_req(fsr), .lnk(lpw_if_inst.dev));
	lpw_core_end lpw_core_end_inst (.i_ref_clk(clk), .i_rst(rst), .i_go(go),
		.i_use_wfi(use_wfi), .i_deep(deep), .i_irq(irq), .o_busy(busy),
		.lnk(lpw_if_inst.core));
	lpw_props #(.REG_UP_CYC(RUP)) lpw_props_inst (.i_ref_clk(clk), .i_rst(rst),
		.i_wfe(lpw_if_inst.wait_for_event_instr), .i_wfi(lpw_if_inst.wait_for_interrupt_instr),
		.i_deep_sleep_request(lpw_if_inst.deep_sleep_request), .i_irq(lpw_if_inst.irq),
		.i_core_clk_en(lpw_if_inst.core_clk_en), .i_core_rst(lpw_if_inst.core_rst),
		.i_awake(lpw_if_inst.awake));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic test_done();
		if (n_fail == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 chk(rdat, exp);
	endtask
	task automatic sleep_req(input logic w, input logic d);
		@(posedge clk);
		go <= 1'b1;
		use_wfi <= w;
		deep <= d;
		@(posedge clk);
		go <= 1'b0;
		cyc(4);
		chk(lpw_if_inst.awake, 0);
		chk(busy, 32'h1);
	endtask
	// bounded wait for the core clock to return
	task automatic wake(output int c);
		c = 0;
		while (lpw_if_inst.awake !== 1'b1) begin
			@(posedge clk);
			c++;
			if (c > 300) begin
				n_fail++;
				$display("MISMATCH %0t wake timed out", $time);
				test_done();
			end
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_sleep();
		wr(LPW_A_SRCEN, 32'h4);
		sleep_req(1'b1, 1'b0);
		chk(pclk, 1);
		chk(reg_on, 1);
		rtc <= 1'b1;
		cyc(6);
		chk(lpw_if_inst.awake, 0);
		irq <= 1'b1;
		wake(n);
		irq <= 1'b0;
		rtc <= 1'b0;
		sleep_req(1'b0, 1'b0);
		rtc <= 1'b1;
		wake(n);
		rtc <= 1'b0;
		chk(lpw_if_inst.core_rst, 0);
	endtask
	task automatic t_wait();
		wr(LPW_A_CTRL, 32'h2);
		wr(LPW_A_CTRL, 32'h3);
		wr(LPW_A_FEN, 32'h1);
		rd(LPW_A_CTRL, 32'h3);
		sleep_req(1'b0, 1'b0);
		chk({pclk, mclk, pwr, reg_on}, 4'h3);
		fst_n <= 19'h7FFFD;
		cyc(3);
		chk({fsr, lpw_if_inst.awake}, 0);
		fst_n <= 19'h7FFFE;
		#1 chk(fsr, 1);
		wake(n);
		fst_n <= 19'h7FFFF;
		chk({mck_rc, rc_en, lpw_if_inst.core_rst}, 3'h6);
	endtask
	task automatic t_backup();
		wr(LPW_A_CTRL, 32'h0);
		wr(LPW_A_SRCEN, 32'h5);
		wr(LPW_A_DEB, 32'h8);
		sleep_req(1'b0, 1'b1);
		chk({reg_on, pwr, hold}, 3'h1);
		real_time_timer <= 1'b1;
		cyc(6);
		chk(lpw_if_inst.core_rst, 0);
		fw_n <= 1'b0;
		cyc(6);
		chk(lpw_if_inst.core_rst, 0);
		wake(n);
		fw_n <= 1'b1;
		real_time_timer <= 1'b0;
		chk(32'(n >= RUP + LPW_RC_UP_CYC), 1);
		chk({pull, pwr, mck_rc}, 3'h7);
	endtask
	initial begin
		cyc(4);
		rst <= 1'b0;
		@(posedge clk);
		#1 chk({reg_on, lpw_if_inst.core_clk_en, fsr}, 3'h6);
		rd(LPW_A_DEB, 32'(LPW_DB_RST));
		rd(4'hF, 32'h0);
		t_sleep();
		t_wait();
		t_backup();
		test_done();
	end
endmodule // tb_low_power_mode_wakeup_ctrl
